// *** hdl/octm_pkg.sv ***
// Constants for the over-current, cooling and PWM timing block
package octm_pkg;

    // ------------------------------------------------------------
    // Clock and base tick
    // ------------------------------------------------------------
    localparam int CLK_NS  = 10;          // pclk period, 100 MHz
    localparam int TICK_NS = 10000;       // Step timer tick, 10 us
    localparam int TICK_CYC = TICK_NS / CLK_NS;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_DUTY     = 8'h04;
    localparam logic [7:0] A_STATUS   = 8'h08;
    localparam logic [7:0] A_IRQ_STAT = 8'h0C;
    localparam logic [7:0] A_IRQ_CLR  = 8'h10;
    localparam logic [7:0] A_IRQ_EN   = 8'h14;
    localparam logic [7:0] A_CAL      = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int F_OC_SEL  = 0;         // CTRL[1:0] over-current profile
    localparam int F_CB_SEL  = 2;         // CTRL[3:2] bulb cooling profile
    localparam int F_PWM_EN  = 4;         // CTRL[4] PWM module enable
    localparam int F_CLK_SEL = 5;         // CTRL[5] 0 ext clock, 1 internal
    localparam int NUM_EV    = 6;         // Interrupt sources
    localparam int EV_CF_LOW = 0;
    localparam int EV_CF_HI  = 1;
    localparam int EV_TOGGLE = 2;
    localparam int EV_OC_END = 3;
    localparam int EV_CB_END = 4;
    localparam int EV_CAL    = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] CTRL_RST = 6'h00;   // Slow OC, medium cooling
    localparam logic [8:0] DUTY_RST = 9'h000;

    // ------------------------------------------------------------
    // Profile codes
    // ------------------------------------------------------------
    localparam logic [1:0] CB_MED_ALT = 2'b11;  // Aliases code 00
    localparam logic [1:0] CB_MED     = 2'b00;
    localparam int OC_STEPS = 7;
    localparam int CB_STEPS = 6;

    // Over-current step times in units of 10 us, [code][step]
    localparam logic [17:0] OC_TICKS [0:3][0:6] = '{
        '{18'd500, 18'd172, 18'd200, 18'd300, 18'd500, 18'd1220, 18'd4460},
        '{18'd248, 18'd80,  18'd104, 18'd158, 18'd224, 18'd612,  18'd2220},
        '{18'd980, 18'd320, 18'd420, 18'd580, 18'd980, 18'd2440, 18'd8920},
        '{18'd1960,18'd640, 18'd840, 18'd1160,18'd1960,18'd4880, 18'd17840}};

    // Bulb cooling step times in units of 10 us, [code][step]
    localparam logic [17:0] CB_TICKS [0:2][0:5] = '{
        '{18'd83400, 18'd44800, 18'd51000, 18'd59600, 18'd71800, 18'd89800},
        '{18'd41800, 18'd22400, 18'd25400, 18'd29000, 18'd36000, 18'd64800},
        '{18'd166800,18'd89400,18'd102200,18'd119200,18'd143400,18'd179600}};

    // ------------------------------------------------------------
    // PWM, clock fail, calibration and toggle timing
    // ------------------------------------------------------------
    localparam int CF_LOW_HZ  = 2000;     // Low frequency fail threshold
    localparam int CF_HIGH_HZ = 200000;   // High frequency fail threshold
    localparam int CF_LOW_CYC  = 1000000000 / (CF_LOW_HZ * CLK_NS);
    localparam int CF_HIGH_CYC = 1000000000 / (CF_HIGH_HZ * CLK_NS);
    localparam int PWM_STEPS  = 256;      // Base ticks per PWM period
    localparam int PWM_MAX_HZ = 1000;     // Output frequency ceiling
    localparam int PWM_DFLT_HZ = 120;     // Uncalibrated output frequency
    localparam int PWM_DIV_MIN =
        (1000000000 + PWM_MAX_HZ * PWM_STEPS * CLK_NS - 1)
        / (PWM_MAX_HZ * PWM_STEPS * CLK_NS);
    localparam int PWM_DIV_DFLT =
        1000000000 / (PWM_DFLT_HZ * PWM_STEPS * CLK_NS);
    localparam int CAL_MIN_US = 20;
    localparam int CAL_MAX_US = 200;
    localparam int CAL_MIN_CYC = CAL_MIN_US * 1000 / CLK_NS;
    localparam int CAL_MAX_CYC = CAL_MAX_US * 1000 / CLK_NS;
    localparam int CAL_SHIFT  = 3;        // Divider = pulse cycles / 8
    localparam int TOGGLE_MS  = 250;
    localparam int TOGGLE_TICKS = TOGGLE_MS * 1000000 / TICK_NS;

endpackage

// *** hdl/octm_top.sv ***
// Over-current, bulb cooling, PWM and input timing block with APB access
`timescale 1ns/1ns

module octm_top #(
    parameter int NUM_IN      = 4,
    parameter int TICK_CYC    = octm_pkg::TICK_CYC,
    parameter int CF_LOW_CYC  = octm_pkg::CF_LOW_CYC,
    parameter int CAL_MAX_CYC = octm_pkg::CAL_MAX_CYC,
    parameter int TOGGLE_TICKS = octm_pkg::TOGGLE_TICKS
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Device pins
    input  wire logic [NUM_IN-1:0] direct_input,
    input  wire logic              cs_n,
    // Protection sequencing
    input  wire logic              oc_run,
    input  wire logic              cb_run,
    // Results
    output logic                   pwm_out,
    output logic [2:0]             oc_step,
    output logic [2:0]             cb_step,
    output logic                   clk_fail,
    output logic                   irq
);

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    typedef enum logic {OCTM_IDLE, OCTM_RUN} octm_seq_t;

    logic [5:0]         ctrl_r;
    logic [8:0]         duty_r;
    logic [5:0]         irq_stat_r;
    logic [5:0]         irq_en_r;
    logic [5:0]         ev;
    logic [5:0]         clr;
    logic [15:0]        tick_cnt_r;
    logic               tick;
    octm_seq_t          oc_st_r;
    octm_seq_t          cb_st_r;
    logic [17:0]        oc_tmr_r;
    logic [17:0]        cb_tmr_r;
    logic [1:0]         cb_code;
    logic [16:0]        cf_cnt_r;
    logic               cf_active;
    logic               in0_d_r;
    logic               in0_rise;
    logic [15:0]        osc_div_r;
    logic [15:0]        osc_cnt_r;
    logic               base_tick;
    logic [7:0]         pwm_cnt_r;
    logic [16:0]        cal_len_r;
    logic               cs_d_r;
    logic [16:0]        cal_div;
    logic [NUM_IN-1:0]  in_d_r;
    logic [NUM_IN-1:0]  tog_to_r;
    logic [NUM_IN-1:0]  tog_ev;
    logic               wr;
    logic               setup;

    wire [1:0] oc_sel  = ctrl_r[octm_pkg::F_OC_SEL +: 2];
    wire [1:0] cb_sel  = ctrl_r[octm_pkg::F_CB_SEL +: 2];
    wire       pwm_en  = ctrl_r[octm_pkg::F_PWM_EN];
    wire       clk_sel = ctrl_r[octm_pkg::F_CLK_SEL];

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr    = psel && penable && pwrite && pready;

    // Zero wait states, read data prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b1;
        end else if (setup) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            case (paddr)
                octm_pkg::A_CTRL:     prdata <= {26'h000_0000, ctrl_r};
                octm_pkg::A_DUTY:     prdata <= {23'h00_0000, duty_r};
                octm_pkg::A_STATUS:   prdata <= 32'({tog_to_r,
                                          pwm_out, clk_fail,
                                          cb_step, oc_step});
                octm_pkg::A_IRQ_STAT: prdata <= {26'h000_0000, irq_stat_r};
                octm_pkg::A_IRQ_CLR:  prdata <= 32'h0000_0000;
                octm_pkg::A_IRQ_EN:   prdata <= {26'h000_0000, irq_en_r};
                octm_pkg::A_CAL:      prdata <= {16'h0000, osc_div_r};
                default:              pslverr <= 1'b1;
            endcase
        end
    end

    // Control and duty registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= octm_pkg::CTRL_RST;
            duty_r   <= octm_pkg::DUTY_RST;
            irq_en_r <= 6'h00;
        end else if (wr) begin
            if (paddr == octm_pkg::A_CTRL)
                ctrl_r <= pwdata[5:0];
            if (paddr == octm_pkg::A_DUTY)
                duty_r <= pwdata[8:0];
            if (paddr == octm_pkg::A_IRQ_EN)
                irq_en_r <= pwdata[5:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign clr = (wr && paddr == octm_pkg::A_IRQ_CLR) ? pwdata[5:0]
                                                      : 6'h00;

    // Sticky status, a new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= 6'h00;
            irq        <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~clr) | ev;
            irq        <= |(((irq_stat_r & ~clr) | ev) & irq_en_r);
        end
    end

    // ------------------------------------------------------------
    // 10 us step tick
    // ------------------------------------------------------------
    assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tick_cnt_r <= 16'h0000;
        else
            tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
    end

    // ------------------------------------------------------------
    // Over-current step sequencer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_st_r  <= OCTM_IDLE;
            oc_step  <= 3'h0;
            oc_tmr_r <= 18'h0_0000;
        end else begin
            case (oc_st_r)
                OCTM_IDLE: if (oc_run) begin
                    oc_st_r  <= OCTM_RUN;
                    oc_step  <= 3'h1;
                    oc_tmr_r <= octm_pkg::OC_TICKS[oc_sel][0];
                end
                OCTM_RUN: if (!oc_run) begin
                    oc_st_r <= OCTM_IDLE;
                    oc_step <= 3'h0;
                end else if (tick) begin
                    if (oc_tmr_r > 18'h0_0001)
                        oc_tmr_r <= oc_tmr_r - 18'h0_0001;
                    else if (oc_step == 3'(octm_pkg::OC_STEPS)) begin
                        oc_st_r <= OCTM_IDLE;
                        oc_step <= 3'h0;
                    end else begin
                        oc_step  <= oc_step + 3'h1;
                        oc_tmr_r <= octm_pkg::OC_TICKS[oc_sel][oc_step];
                    end
                end
                default: oc_st_r <= OCTM_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bulb cooling step sequencer
    // ------------------------------------------------------------
    assign cb_code = (cb_sel == octm_pkg::CB_MED_ALT) ? octm_pkg::CB_MED
                                                      : cb_sel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cb_st_r  <= OCTM_IDLE;
            cb_step  <= 3'h0;
            cb_tmr_r <= 18'h0_0000;
        end else begin
            case (cb_st_r)
                OCTM_IDLE: if (cb_run) begin
                    cb_st_r  <= OCTM_RUN;
                    cb_step  <= 3'h1;
                    cb_tmr_r <= octm_pkg::CB_TICKS[cb_code][0];
                end
                OCTM_RUN: if (!cb_run) begin
                    cb_st_r <= OCTM_IDLE;
                    cb_step <= 3'h0;
                end else if (tick) begin
                    if (cb_tmr_r > 18'h0_0001)
                        cb_tmr_r <= cb_tmr_r - 18'h0_0001;
                    else if (cb_step == 3'(octm_pkg::CB_STEPS)) begin
                        cb_st_r <= OCTM_IDLE;
                        cb_step <= 3'h0;
                    end else begin
                        cb_step  <= cb_step + 3'h1;
                        cb_tmr_r <= octm_pkg::CB_TICKS[cb_code][cb_step];
                    end
                end
                default: cb_st_r <= OCTM_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // External clock fail detector on direct input 0
    // ------------------------------------------------------------
    assign cf_active = pwm_en && !clk_sel;
    assign in0_rise  = direct_input[0] && !in0_d_r;

    // Period counter, saturates once the low threshold is reached
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in0_d_r  <= 1'b0;
            cf_cnt_r <= 17'h0_0000;
            clk_fail <= 1'b0;
        end else begin
            in0_d_r <= direct_input[0];
            if (!cf_active) begin
                cf_cnt_r <= 17'h0_0000;
                clk_fail <= 1'b0;
            end else if (in0_rise) begin
                cf_cnt_r <= 17'h0_0000;
                clk_fail <= (cf_cnt_r < 17'(octm_pkg::CF_HIGH_CYC));
            end else if (cf_cnt_r < 17'(CF_LOW_CYC)) begin
                cf_cnt_r <= cf_cnt_r + 17'h0_0001;
            end else begin
                clk_fail <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // PWM generator
    // ------------------------------------------------------------
    assign base_tick = clk_sel ? (osc_cnt_r == 16'h0000)
                               : (in0_rise && !clk_fail);

    // Internal oscillator from the calibrated divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            osc_cnt_r <= 16'h0000;
        else if (osc_cnt_r == 16'h0000)
            osc_cnt_r <= osc_div_r - 16'h0001;
        else
            osc_cnt_r <= osc_cnt_r - 16'h0001;
    end

    // Period counter and duty compare; 0 holds off, 256 holds on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt_r <= 8'h00;
            pwm_out   <= 1'b0;
        end else begin
            if (base_tick)
                pwm_cnt_r <= pwm_cnt_r + 8'h01;
            pwm_out <= pwm_en && ({1'b0, pwm_cnt_r} < duty_r);
        end
    end

    // ------------------------------------------------------------
    // Chip-select calibration
    // ------------------------------------------------------------
    assign cal_div = cal_len_r >> octm_pkg::CAL_SHIFT;

    // Measure low time, accept only inside the window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_d_r    <= 1'b1;
            cal_len_r <= 17'h0_0000;
            osc_div_r <= 16'(octm_pkg::PWM_DIV_DFLT);
        end else begin
            cs_d_r <= cs_n;
            if (!cs_n) begin
                if (cal_len_r < 17'(CAL_MAX_CYC + 1))
                    cal_len_r <= cal_len_r + 17'h0_0001;
            end else begin
                cal_len_r <= 17'h0_0000;
            end
            if (ev[octm_pkg::EV_CAL]) begin
                if (cal_div < 17'(octm_pkg::PWM_DIV_MIN))
                    osc_div_r <= 16'(octm_pkg::PWM_DIV_MIN);
                else
                    osc_div_r <= cal_div[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Direct input toggle timeout
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_IN; i++) begin : g_tog
        logic [15:0] cnt_r;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                in_d_r[i]   <= 1'b0;
                cnt_r       <= 16'h0000;
                tog_to_r[i] <= 1'b0;
            end else begin
                in_d_r[i] <= direct_input[i];
                if (direct_input[i] != in_d_r[i]) begin
                    cnt_r       <= 16'h0000;
                    tog_to_r[i] <= 1'b0;
                end else if (tick && !tog_to_r[i]) begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == 16'(TOGGLE_TICKS - 1))
                        tog_to_r[i] <= 1'b1;
                end
            end
        end
        assign tog_ev[i] = tick && !tog_to_r[i]
                        && direct_input[i] == in_d_r[i]
                        && cnt_r == 16'(TOGGLE_TICKS - 1);
    end

    // ------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------
    always_comb begin
        ev = 6'h00;
        ev[octm_pkg::EV_CF_LOW] = cf_active && !in0_rise
                               && cf_cnt_r == 17'(CF_LOW_CYC - 1);
        ev[octm_pkg::EV_CF_HI]  = cf_active && in0_rise
                               && cf_cnt_r < 17'(octm_pkg::CF_HIGH_CYC);
        ev[octm_pkg::EV_TOGGLE] = |tog_ev;
        ev[octm_pkg::EV_OC_END] = oc_st_r == OCTM_RUN && oc_run && tick
                               && oc_tmr_r <= 18'h0_0001
                               && oc_step == 3'(octm_pkg::OC_STEPS);
        ev[octm_pkg::EV_CB_END] = cb_st_r == OCTM_RUN && cb_run && tick
                               && cb_tmr_r <= 18'h0_0001
                               && cb_step == 3'(octm_pkg::CB_STEPS);
        ev[octm_pkg::EV_CAL]    = cs_n && !cs_d_r
                               && cal_len_r >= 17'(octm_pkg::CAL_MIN_CYC)
                               && cal_len_r <= 17'(CAL_MAX_CYC);
    end

endmodule // octm_top

// *** dv/octm_host.sv ***
// Host side model: PWM clock on input 0 and calibration pulses
`timescale 1ns/1ns
module octm_host (
    // Clock
    input  wire logic pclk,
    // Device pins
    output logic      in0,
    output logic      cs_n
);
    int half = 0;    // Half period in cycles, 0 stops the clock
    int cnt  = 0;

    initial begin
        in0  = 1'b0;
        cs_n = 1'b1;
    end

    // PWM clock on input 0, parked low like the pin's pull-down
    always @(posedge pclk) begin
        if (half == 0) begin
            in0 <= 1'b0;
            cnt <= 0;
        end else if (cnt >= half - 1) begin
            in0 <= ~in0;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end

    // Chip-select low pulse lasting n cycles
    task cal_pulse(input int n);
        @(posedge pclk);
        cs_n <= 1'b0;
        repeat (n) @(posedge pclk);
        cs_n <= 1'b1;
    endtask
endmodule // octm_host

// *** dv/octm_checker.sv ***
// Port checker for the timing block
`timescale 1ns/1ns
module octm_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Sequencers
    input wire logic        oc_run,
    input wire logic        cb_run,
    input wire logic [2:0]  oc_step,
    input wire logic [2:0]  cb_step
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Start of a sequence from idle
    sequence oc_go;
        $rose(oc_run) && oc_step == 3'h0;
    endsequence
    sequence cb_go;
        $rose(cb_run) && cb_step == 3'h0;
    endsequence

    pready_hi_a: assert property (pready)
        else $error("pready low");
    slverr_map_a: assert property (psel && penable && paddr > 8'h18
        |-> pslverr) else $error("no error on unmapped access");
    err_rdzero_a: assert property (psel && penable && !pwrite && pslverr
        |-> prdata == 32'h0) else $error("error read not zero");
    oc_start_a: assert property (oc_go |=> oc_step == 3'h1)
        else $error("OC step 1 not started");
    cb_start_a: assert property (cb_go |=> cb_step == 3'h1)
        else $error("cooling step 1 not started");
    oc_order_a: assert property (oc_run && $past(oc_run)
        && oc_step != $past(oc_step) |-> oc_step == $past(oc_step) + 3'h1
        || (oc_step == 3'h0 && $past(oc_step) == 3'h7))
        else $error("OC step out of order");
    cb_order_a: assert property (cb_run && $past(cb_run)
        && cb_step != $past(cb_step) |-> cb_step == $past(cb_step) + 3'h1
        || (cb_step == 3'h0 && $past(cb_step) == 3'h6))
        else $error("cooling step out of order");
    oc_drop_a: assert property (!oc_run |=> oc_step == 3'h0)
        else $error("OC step kept after run low");
    cb_range_a: assert property (cb_step <= 3'h6)
        else $error("cooling step above six");
endmodule // octm_checker

// *** dv/overcurrent_cooling_pwm_timing_test.sv ***
// Self-checking bench for the timing block
`timescale 1ns/1ns
module overcurrent_cooling_pwm_timing_test;
    localparam int TC = 1;                 // Step tick in cycles
    typedef struct { logic [1:0] sel; int ticks; } octm_row_t;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [2:0]  di_hi   = 3'b000;
    logic        oc_run  = 1'b0;
    logic        cb_run  = 1'b0;
    logic [31:0] prdata, rd;
    logic [2:0]  oc_step, cb_step;
    logic        pready, pslverr, in0, cs_n, pwm_out, clk_fail, irq, err;
    int          errors = 0, n_compared = 0, n;
    octm_row_t   rows [4] = '{'{2'b00, 500}, '{2'b01, 248},
                              '{2'b10, 980}, '{2'b11, 1960}};

    always #5 pclk = ~pclk;

    octm_top #(.TICK_CYC(TC), .CF_LOW_CYC(2000), .CAL_MAX_CYC(4000),
               .TOGGLE_TICKS(20)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .direct_input({di_hi, in0}),
        .cs_n(cs_n), .oc_run(oc_run), .cb_run(cb_run), .pwm_out(pwm_out),
        .oc_step(oc_step), .cb_step(cb_step), .clk_fail(clk_fail),
        .irq(irq));
    octm_host host_u (.pclk(pclk), .in0(in0), .cs_n(cs_n));

    task final_report;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] m, e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, e);
    endtask
    // Waits for a step, then counts the cycles it lasts
    task meas(input logic cb, input logic [2:0] st);
        int k;
        k = 0;
        n = 0;
        while ((cb ? cb_step : oc_step) !== st && k < 20000) begin
            @(posedge pclk);
            k++;
        end
        while ((cb ? cb_step : oc_step) === st && n < 60000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task near(input int exp);
        chk({31'h0, n >= exp - 2 && n <= exp + 2}, 32'h1);
    endtask
    // Waits w edges, then looks at irq (0), clk_fail (1) or pwm_out (2)
    task pin(input int s, input logic e, input int w);
        repeat (w) @(posedge pclk);
        chk({31'h0, (s == 0) ? irq : (s == 1) ? clk_fail : pwm_out},
            {31'h0, e});
    endtask

    // Watchdog
    initial begin
        repeat (95000) @(posedge pclk);
        errors++;
        final_report;
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk(8'h00, 32'hFFFF_FFFF, 32'h0);
        rchk(8'h18, 32'h0000_FFFF, 32'd3255);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // First step of every over-current profile
        foreach (rows[i]) begin
            apb(1'b1, 8'h00, {30'h0, rows[i].sel});
            oc_run <= 1'b1;
            meas(1'b0, 3'h1);
            near(rows[i].ticks * TC);
            oc_run <= 1'b0;
            @(posedge pclk);
        end
        // Full slow sequence, then fast cooling
        apb(1'b1, 8'h00, 32'h0000_0004);
        oc_run <= 1'b1;
        meas(1'b0, 3'h7);
        near(4460 * TC);
        rchk(8'h0C, 32'h0000_0008, 32'h0000_0008);
        cb_run <= 1'b1;
        meas(1'b1, 3'h1);
        near(41800 * TC);
        chk({29'h0, cb_step}, 32'h2);
        cb_run <= 1'b0;
        oc_run <= 1'b0;
        // Interrupt enable, mask and clear
        apb(1'b1, 8'h14, 32'h0000_0008);
        pin(0, 1'b1, 3);
        apb(1'b1, 8'h14, 32'h0000_0000);
        pin(0, 1'b0, 3);
        apb(1'b1, 8'h14, 32'h0000_0008);
        apb(1'b1, 8'h10, 32'h0000_0008);
        pin(0, 1'b0, 3);
        rchk(8'h0C, 32'h0000_0008, 32'h0);
        // Idle inputs time out, changing inputs 1 to 3 clears their flags
        rchk(8'h08, 32'h0000_0E00, 32'h0000_0E00);
        di_hi <= 3'b111;
        rchk(8'h08, 32'h0000_0E00, 32'h0);
        // External clock: good, too fast, good, stopped
        apb(1'b1, 8'h00, 32'h0000_0010);
        host_u.half <= 500;
        pin(1, 1'b0, 3000);
        host_u.half <= 100;
        pin(1, 1'b1, 1000);
        host_u.half <= 500;
        pin(1, 1'b0, 3000);
        host_u.half <= 0;
        pin(1, 1'b1, 2600);
        rchk(8'h0C, 32'h0000_0003, 32'h0000_0003);
        apb(1'b1, 8'h00, 32'h0000_0030);
        pin(1, 1'b0, 3);
        // Duty mid-range written without a check, then fully off and fully on
        apb(1'b1, 8'h04, 32'h0000_0080);
        apb(1'b1, 8'h04, 32'h0000_0000);
        pin(2, 1'b0, 20);
        apb(1'b1, 8'h04, 32'h0000_0100);
        pin(2, 1'b1, 20);
        // Calibration pulses: short, long, clamped, accepted
        host_u.cal_pulse(1500);
        rchk(8'h18, 32'h0000_FFFF, 32'd3255);
        host_u.cal_pulse(4500);
        rchk(8'h18, 32'h0000_FFFF, 32'd3255);
        host_u.cal_pulse(2500);
        rchk(8'h18, 32'h0000_FFFF, 32'd391);
        host_u.cal_pulse(3500);
        rchk(8'h18, 32'h0000_FFFF, 32'd437);
        rchk(8'h0C, 32'h0000_0020, 32'h0000_0020);
        final_report;
    end
endmodule // overcurrent_cooling_pwm_timing_test

bind octm_top octm_checker chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oc_run(oc_run), .cb_run(cb_run),
    .oc_step(oc_step), .cb_step(cb_step));
